//--- common/pec_pkg.sv
// Shared constants, link states and checksum helper for the two-wire slave.
package pec_pkg;

  localparam logic [7:0] PEC_POLY   = 8'h07;
  localparam logic [7:0] PEC_INIT   = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [1:0] BYTE_FRAME = 2'h2;
  localparam logic [1:0] WORD_FRAME = 2'h3;
  localparam logic [1:0] IDX_HIGH   = 2'h1;
  localparam logic       DIR_READ   = 1'b1;

  // One accepted write as handed to the user side.
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] data;
    logic        word;
  } wr_s;

  localparam int WR_W = $bits(wr_s);

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_RX   = 3'b001,
    L_ACK  = 3'b010,
    L_WAIT = 3'b011,
    L_TX   = 3'b100,
    L_MACK = 3'b101,
    L_SKIP = 3'b110
  } link_state_e;

  // Folds one byte into the running packet checksum, MSB first.
  function automatic logic [7:0] pec_update(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
    end
    return c;
  endfunction : pec_update

endpackage : pec_pkg

//--- common/stream_if.sv
// Valid and ready stream between the slave and its output buffer.
`timescale 1ns/100ps
interface stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

//--- verilog/pair_buffer.sv
// Two-entry buffer with registered outputs on both sides.
`timescale 1ns/100ps
module pair_buffer (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  stream_if.snk     up,
  stream_if.src     down
);

  logic                   head_v;
  logic                   spare_v;
  logic [pec_pkg::WR_W-1:0] head;
  logic [pec_pkg::WR_W-1:0] spare;
  logic                   next_head_v;
  logic                   next_spare_v;
  logic [pec_pkg::WR_W-1:0] next_head;
  logic [pec_pkg::WR_W-1:0] next_spare;

  // Ready falls only when the spare slot holds a word, so a stall never drops one.
  assign up.ready   = ~spare_v;
  assign down.valid = head_v;
  assign down.data  = head;

  // Pop moves the spare forward, push fills the first free slot.
  always_comb begin
    next_head_v  = head_v;
    next_spare_v = spare_v;
    next_head    = head;
    next_spare   = spare;
    if (head_v && down.ready) begin
      if (spare_v) begin
        next_head    = spare;
        next_spare_v = 1'b0;
      end else begin
        next_head_v = 1'b0;
      end
    end
    if (up.valid && !spare_v) begin
      if (!next_head_v) begin
        next_head_v = 1'b1;
        next_head   = up.data;
      end else begin
        next_spare_v = 1'b1;
        next_spare   = up.data;
      end
    end
  end

  // Registers the buffer state.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      head_v  <= 1'b0;
      spare_v <= 1'b0;
      head    <= '0;
      spare   <= '0;
    end else begin
      head_v  <= next_head_v;
      spare_v <= next_spare_v;
      head    <= next_head;
      spare   <= next_spare;
    end
  end

endmodule : pair_buffer

//--- verilog/two_wire_slave.sv
// Two-wire bus slave with packet checksum, link domain and user side.
`timescale 1ns/100ps
module two_wire_slave #(
  parameter logic [6:0] OWN_ADDR = 7'h2A
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [7:0]       wr_cmd,
  output logic [15:0]      wr_data,
  output logic             wr_word,
  output logic             rd_req,
  output logic [7:0]       rd_cmd,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_word
);

  // Link domain state.
  logic                  lr1;
  logic                  lr2;
  logic                  scl1;
  logic                  scl_s;
  logic                  scl_q;
  logic                  sda1;
  logic                  sda_s;
  logic                  sda_q;
  logic                  ak1;
  logic                  ak2;
  logic                  rs1;
  logic                  rs2;
  pec_pkg::link_state_e  state;
  pec_pkg::link_state_e  next_state;
  logic [3:0]            bitcnt;
  logic [3:0]            next_bitcnt;
  logic [7:0]            shreg;
  logic [7:0]            next_shreg;
  logic                  addr_phase;
  logic                  next_addr_phase;
  logic                  cmd_seen;
  logic                  next_cmd_seen;
  logic                  rd_mode;
  logic                  next_rd_mode;
  logic [1:0]            rx_count;
  logic [1:0]            next_rx_count;
  logic [7:0]            cmd;
  logic [7:0]            next_cmd;
  logic [7:0]            b0;
  logic [7:0]            next_b0;
  logic [7:0]            b1;
  logic [7:0]            next_b1;
  logic [7:0]            crc;
  logic [7:0]            next_crc;
  logic [1:0]            tx_idx;
  logic [1:0]            next_tx_idx;
  logic                  mack;
  logic                  next_mack;
  logic                  next_sda_oe;
  logic                  next_scl_oe;
  logic                  wr_tgl;
  logic                  next_wr_tgl;
  pec_pkg::wr_s          wr_hold;
  pec_pkg::wr_s          next_wr_hold;
  logic                  rq_tgl;
  logic                  next_rq_tgl;

  // Reference domain state.
  logic                  wt1;
  logic                  wt2;
  logic                  wt_seen;
  logic                  next_wt_seen;
  logic                  ack_tgl;
  logic                  next_ack_tgl;
  logic                  push_v;
  logic                  next_push_v;
  pec_pkg::wr_s          push_data;
  pec_pkg::wr_s          next_push_data;
  logic                  rq1;
  logic                  rq2;
  logic                  rq_seen;
  logic                  next_rq_seen;
  logic                  next_rd_req;
  logic [7:0]            next_rd_cmd;
  logic                  rs_tgl;
  logic                  next_rs_tgl;
  logic [15:0]           ans_data;
  logic [15:0]           next_ans_data;
  logic                  ans_word;
  logic                  next_ans_word;

  // Link events and crossing status.
  logic                  rise;
  logic                  fall;
  logic                  start;
  logic                  stop;
  logic                  wr_pend;
  logic                  rd_pend;
  logic [7:0]            tx_next;
  pec_pkg::wr_s          out_word;

  stream_if #(.W(pec_pkg::WR_W)) in_if ();
  stream_if #(.W(pec_pkg::WR_W)) out_if ();

  // Clock edges and bus conditions seen on the synchronised pins.
  assign rise  = scl_s & ~scl_q;
  assign fall  = ~scl_s & scl_q;
  assign start = scl_s & scl_q & sda_q & ~sda_s;
  assign stop  = scl_s & scl_q & ~sda_q & sda_s;
  assign wr_pend = wr_tgl ^ ak2;
  assign rd_pend = rq_tgl ^ rs2;
  // The high byte follows the low byte of a word answer; otherwise the checksum is next.
  assign tx_next = ((tx_idx == '0) && ans_word) ? ans_data[15:8] : crc;

  // Pin and handshake synchronisers plus link reset; first stages feed only second stages.
  always_ff @(posedge link_clk) begin
    lr1   <= rst_n;
    lr2   <= lr1;
    scl1  <= scl_in;
    scl_s <= scl1;
    scl_q <= scl_s;
    sda1  <= sda_in;
    sda_s <= sda1;
    sda_q <= sda_s;
    ak1   <= ack_tgl;
    ak2   <= ak1;
    rs1   <= rs_tgl;
    rs2   <= rs1;
  end

  // Byte engine on the link clock; it only leaves L_IDLE on the master's START.
  always_comb begin
    next_state      = state;
    next_bitcnt     = bitcnt;
    next_shreg      = shreg;
    next_addr_phase = addr_phase;
    next_cmd_seen   = cmd_seen;
    next_rd_mode    = rd_mode;
    next_rx_count   = rx_count;
    next_cmd        = cmd;
    next_b0         = b0;
    next_b1         = b1;
    next_crc        = crc;
    next_tx_idx     = tx_idx;
    next_mack       = mack;
    next_sda_oe     = sda_oe;
    next_scl_oe     = scl_oe;
    next_wr_tgl     = wr_tgl;
    next_wr_hold    = wr_hold;
    next_rq_tgl     = rq_tgl;
    if (stop) begin
      // Only complete, acknowledged frames with a clean checksum are passed on.
      if (!rd_mode && cmd_seen && !wr_pend && crc == pec_pkg::PEC_INIT &&
          (rx_count == pec_pkg::BYTE_FRAME || rx_count == pec_pkg::WORD_FRAME)) begin
        next_wr_hold.cmd  = cmd;
        next_wr_hold.word = (rx_count == pec_pkg::WORD_FRAME);
        next_wr_hold.data = (rx_count == pec_pkg::WORD_FRAME) ? {b1, b0} : {pec_pkg::ZERO_BYTE, b0};
        next_wr_tgl       = ~wr_tgl;
      end
      next_state  = pec_pkg::L_IDLE;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
    end else if (start) begin
      // A fresh START clears the frame; a repeated START keeps command and checksum.
      if (state == pec_pkg::L_IDLE) begin
        next_crc      = pec_pkg::PEC_INIT;
        next_cmd_seen = 1'b0;
      end
      next_state      = pec_pkg::L_RX;
      next_bitcnt     = '0;
      next_addr_phase = 1'b1;
      next_rx_count   = '0;
      next_rd_mode    = 1'b0;
      next_sda_oe     = 1'b0;
      next_scl_oe     = 1'b0;
    end else begin
      case (state)
        pec_pkg::L_RX: begin
          next_sda_oe = 1'b0;
          if (rise) begin
            next_shreg  = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (fall && bitcnt == pec_pkg::BYTE_BITS) begin
            next_state  = pec_pkg::L_ACK;
            next_sda_oe = 1'b1;
            next_crc    = pec_pkg::pec_update(crc, shreg);
            if (addr_phase) begin
              if (shreg[7:1] == OWN_ADDR && (shreg[0] != pec_pkg::DIR_READ || cmd_seen)) begin
                next_addr_phase = 1'b0;
                next_rd_mode    = (shreg[0] == pec_pkg::DIR_READ);
              end else begin
                next_state  = pec_pkg::L_SKIP;
                next_sda_oe = 1'b0;
              end
            end else if (!cmd_seen) begin
              next_cmd      = shreg;
              next_cmd_seen = 1'b1;
            end else if (rx_count != pec_pkg::WORD_FRAME) begin
              if (rx_count == '0) begin
                next_b0 = shreg;
              end
              if (rx_count == pec_pkg::IDX_HIGH) begin
                next_b1 = shreg;
              end
              next_rx_count = rx_count + 2'h1;
            end else begin
              next_state  = pec_pkg::L_SKIP;
              next_sda_oe = 1'b0;
            end
          end
        end
        pec_pkg::L_ACK: begin
          if (fall) begin
            next_sda_oe = 1'b0;
            next_bitcnt = '0;
            if (rd_mode) begin
              next_state  = pec_pkg::L_WAIT;
              next_scl_oe = 1'b1;
              next_rq_tgl = ~rq_tgl;
            end else if (wr_pend) begin
              next_state  = pec_pkg::L_WAIT;
              next_scl_oe = 1'b1;
            end else begin
              next_state = pec_pkg::L_RX;
            end
          end
        end
        pec_pkg::L_WAIT: begin
          // Clock stays held until the user answers or the buffer frees up.
          if (rd_mode && !rd_pend) begin
            next_state  = pec_pkg::L_TX;
            next_shreg  = ans_data[7:0];
            next_sda_oe = ~ans_data[7];
            next_crc    = pec_pkg::pec_update(crc, ans_data[7:0]);
            next_tx_idx = '0;
            next_scl_oe = 1'b0;
          end else if (!rd_mode && !wr_pend) begin
            next_state  = pec_pkg::L_RX;
            next_scl_oe = 1'b0;
          end
        end
        pec_pkg::L_TX: begin
          if (fall) begin
            if (bitcnt == pec_pkg::LAST_BIT) begin
              next_state  = pec_pkg::L_MACK;
              next_sda_oe = 1'b0;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        pec_pkg::L_MACK: begin
          if (rise) begin
            next_mack = ~sda_s;
          end else if (fall) begin
            next_tx_idx = tx_idx + 2'h1;
            if (mack && tx_idx != (ans_word ? pec_pkg::BYTE_FRAME : pec_pkg::IDX_HIGH)) begin
              next_state  = pec_pkg::L_TX;
              next_shreg  = tx_next;
              next_sda_oe = ~tx_next[7];
              next_crc    = pec_pkg::pec_update(crc, tx_next);
              next_bitcnt = '0;
            end else begin
              next_state = pec_pkg::L_SKIP;
            end
          end
        end
        pec_pkg::L_SKIP: begin
          next_sda_oe = 1'b0;
          next_scl_oe = 1'b0;
        end
        default: begin
          next_sda_oe = 1'b0;
          next_scl_oe = 1'b0;
        end
      endcase
    end
  end

  // Registers the link engine; the pins are released during reset.
  always_ff @(posedge link_clk) begin
    if (!lr2) begin
      state      <= pec_pkg::L_IDLE;
      bitcnt     <= '0;
      shreg      <= '0;
      addr_phase <= 1'b0;
      cmd_seen   <= 1'b0;
      rd_mode    <= 1'b0;
      rx_count   <= '0;
      cmd        <= '0;
      b0         <= '0;
      b1         <= '0;
      crc        <= pec_pkg::PEC_INIT;
      tx_idx     <= '0;
      mack       <= 1'b0;
      sda_oe     <= 1'b0;
      scl_oe     <= 1'b0;
      sda_out    <= 1'b0;
      scl_out    <= 1'b0;
      wr_tgl     <= 1'b0;
      wr_hold    <= '0;
      rq_tgl     <= 1'b0;
    end else begin
      state      <= next_state;
      bitcnt     <= next_bitcnt;
      shreg      <= next_shreg;
      addr_phase <= next_addr_phase;
      cmd_seen   <= next_cmd_seen;
      rd_mode    <= next_rd_mode;
      rx_count   <= next_rx_count;
      cmd        <= next_cmd;
      b0         <= next_b0;
      b1         <= next_b1;
      crc        <= next_crc;
      tx_idx     <= next_tx_idx;
      mack       <= next_mack;
      sda_oe     <= next_sda_oe;
      scl_oe     <= next_scl_oe;
      sda_out    <= 1'b0;  // Open drain: only ever pulls low.
      scl_out    <= 1'b0;
      wr_tgl     <= next_wr_tgl;
      wr_hold    <= next_wr_hold;
      rq_tgl     <= next_rq_tgl;
    end
  end

  // Toggle synchronisers into the reference domain.
  always_ff @(posedge ref_clk) begin
    wt1 <= wr_tgl;
    wt2 <= wt1;
    rq1 <= rq_tgl;
    rq2 <= rq1;
  end

  // Takes held link words into the buffer and serves read requests to the user.
  always_comb begin
    next_wt_seen   = wt_seen;
    next_ack_tgl   = ack_tgl;
    next_push_v    = push_v;
    next_push_data = push_data;
    next_rq_seen   = rq_seen;
    next_rd_req    = rd_req;
    next_rd_cmd    = rd_cmd;
    next_rs_tgl    = rs_tgl;
    next_ans_data  = ans_data;
    next_ans_word  = ans_word;
    if (push_v && in_if.ready) begin
      next_push_v  = 1'b0;
      next_ack_tgl = ~ack_tgl;
    end else if (!push_v && wt2 != wt_seen) begin
      next_push_v    = 1'b1;
      next_push_data = wr_hold;
      next_wt_seen   = wt2;
    end
    if (rd_req && rd_valid) begin
      next_rd_req   = 1'b0;
      next_ans_data = rd_data;
      next_ans_word = rd_word;
      next_rs_tgl   = ~rs_tgl;
    end else if (!rd_req && rq2 != rq_seen) begin
      next_rd_req  = 1'b1;
      next_rd_cmd  = cmd;
      next_rq_seen = rq2;
    end
  end

  // Registers the reference side.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wt_seen   <= 1'b0;
      ack_tgl   <= 1'b0;
      push_v    <= 1'b0;
      push_data <= '0;
      rq_seen   <= 1'b0;
      rd_req    <= 1'b0;
      rd_cmd    <= '0;
      rs_tgl    <= 1'b0;
      ans_data  <= '0;
      ans_word  <= 1'b0;
    end else begin
      wt_seen   <= next_wt_seen;
      ack_tgl   <= next_ack_tgl;
      push_v    <= next_push_v;
      push_data <= next_push_data;
      rq_seen   <= next_rq_seen;
      rd_req    <= next_rd_req;
      rd_cmd    <= next_rd_cmd;
      rs_tgl    <= next_rs_tgl;
      ans_data  <= next_ans_data;
      ans_word  <= next_ans_word;
    end
  end

  // Write words pass through the two-entry buffer to the user.
  assign in_if.valid  = push_v;
  assign in_if.data   = push_data;
  assign out_if.ready = wr_ready;
  assign out_word     = out_if.data;
  assign wr_valid     = out_if.valid;
  assign wr_cmd       = out_word.cmd;
  assign wr_data      = out_word.data;
  assign wr_word      = out_word.word;

  pair_buffer u_buffer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .up      (in_if.snk),
    .down    (out_if.src)
  );

endmodule : two_wire_slave

//--- tb/two_wire_slave_properties.sv
// Concurrent checks on the pins and user ports of the two-wire slave.
`timescale 1ns/100ps
module two_wire_slave_properties (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        link_clk,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [7:0]  wr_cmd,
  input wire logic [15:0] wr_data,
  input wire logic        wr_word,
  input wire logic        rd_req,
  input wire logic [7:0]  rd_cmd,
  input wire logic        rd_valid
);
  // Pin checks run on the link clock, user port checks on the user clock.
  a_sda_pull_only:
    assert property (@(posedge link_clk) disable iff (!rst_n) sda_oe |-> !sda_out)
    else $error("data pin driven high");
  a_scl_pull_only:
    assert property (@(posedge link_clk) disable iff (!rst_n) scl_oe |-> !scl_out)
    else $error("clock pin driven high");
  a_sda_quiet_high:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      $changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("data drive changed while clock high");
  a_ack_holds_high:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      sda_oe && scl_in |=> sda_oe)
    else $error("data low released while clock high");
  a_stretch_low_only:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(scl_oe) |-> !$past(scl_in, 1))
    else $error("stretch began while clock high");
  a_wr_word_holds:
    assert property (@(posedge ref_clk) disable iff (!rst_n) wr_valid && !wr_ready
      |=> wr_valid && $stable(wr_data) && $stable(wr_cmd) && $stable(wr_word))
    else $error("write word changed before taken");
  a_byte_high_zero:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_valid && !wr_word |-> wr_data[15:8] == 8'h00)
    else $error("byte write with nonzero high byte");
  a_rd_req_holds:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_req && !rd_valid |=> rd_req && $stable(rd_cmd))
    else $error("read request dropped early");
  a_rd_req_drops:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_req && rd_valid |=> !rd_req)
    else $error("read request held after answer");
endmodule : two_wire_slave_properties

bind two_wire_slave two_wire_slave_properties u_two_wire_slave_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_cmd(wr_cmd), .wr_data(wr_data),
  .wr_word(wr_word), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_valid(rd_valid));

//--- tb/bus_host.sv
// Behavioural bus master that drives frames onto the two-wire bus.
`timescale 1ns/100ps
module bus_host (
  input  wire logic link_clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe,
  output logic      stuck
);
  // High phase of one bus clock and half of its low phase, in link clock cycles.
  localparam int H = 40;

  // Both lines start released so the bus idles high.
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stuck = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask : tick

  // Releases the clock and waits, bounded, while the slave stretches it.
  task automatic rise;
    int k;
    scl_oe <= 1'b0;
    tick(1);
    for (k = 0; k < 5000 && scl !== 1'b1; k++) tick(1);
    if (k == 5000) stuck <= 1'b1;
    tick(H);
  endtask : rise

  // Data moves only while the clock is low; the level is read late in the high phase.
  task automatic bit_out(input logic b, output logic r);
    sda_oe <= !b;
    tick(H);
    rise;
    r = sda;
    scl_oe <= 1'b1;
    tick(H);
  endtask : bit_out

  // One byte MSB first, then the ninth clock carries the acknowledge.
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_out(d[i], q[i]);
    bit_out(nak, a);
  endtask : xfer

  // Data falls under a high clock; also serves as a repeated start.
  task automatic start;
    sda_oe <= 1'b0;
    tick(H);
    rise;
    sda_oe <= 1'b1;
    tick(H);
    scl_oe <= 1'b1;
    tick(H);
  endtask : start

  // Data rises under a high clock and the bus is left idle.
  task automatic stop;
    sda_oe <= 1'b1;
    tick(H);
    rise;
    sda_oe <= 1'b0;
    tick(H);
  endtask : stop
endmodule : bus_host

//--- tb/two_wire_slave_bench.sv
// Self-checking bench for the two-wire slave with a behavioural bus master.
`timescale 1ns/100ps
module two_wire_slave_bench;
  localparam logic [6:0] ADDR = 7'h2A;
  logic        ref_clk, link_clk, rst_n, wr_ready, rd_valid, rd_word;
  logic        scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe, stuck;
  logic        wr_valid, wr_word, rd_req;
  logic [7:0]  wr_cmd, rd_cmd;
  logic [15:0] wr_data, rd_data;
  wire         scl, sda;
  int          errors, checked;

  // Open-drain wires with pull-ups: low while any party enables its driver.
  assign scl = !(scl_oe || m_scl_oe);
  assign sda = !(sda_oe || m_sda_oe);

  two_wire_slave #(.OWN_ADDR(ADDR)) u_two_wire_slave (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_cmd(wr_cmd),
    .wr_data(wr_data), .wr_word(wr_word), .rd_req(rd_req), .rd_cmd(rd_cmd),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_word(rd_word));

  bus_host u_bus_host (.link_clk(link_clk), .scl(scl), .sda(sda),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .stuck(stuck));

  // User clock, and a link clock of unrelated phase.
  always #5 ref_clk = !ref_clk;
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = !link_clk;
  end

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
    return x;
  endfunction : crc

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic close_out;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Sends one byte, folds it into the checksum and gathers refusals.
  task automatic put(input logic [7:0] b, inout logic [7:0] p, inout logic n);
    logic [7:0] q;
    logic       a;
    u_bus_host.xfer(b, 1'b1, q, a);
    p = crc(p, b);
    n = n | a;
  endtask : put

  // Whole write frame; flip spoils the checksum, cut adds a broken byte.
  task automatic wr_frame(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                          input logic w, input logic [7:0] flip, input logic cut,
                          output logic n);
    logic [7:0] p;
    logic       r;
    p = 8'h00;
    n = 1'b0;
    u_bus_host.start;
    put({a, 1'b0}, p, n);
    put(c, p, n);
    put(d[7:0], p, n);
    if (w) put(d[15:8], p, n);
    put(p ^ flip, p, n);
    if (cut) repeat (3) u_bus_host.bit_out(1'b0, r);
    u_bus_host.stop;
    chk(stuck, 1'b0);
    if (stuck) close_out;
  endtask : wr_frame

  // Waits for a buffered word, compares it, then takes it.
  task automatic pop(input logic [7:0] c, input logic [15:0] d, input logic w);
    int k;
    @(negedge ref_clk);
    for (k = 0; k < 400 && wr_valid !== 1'b1; k++) @(negedge ref_clk);
    chk(wr_valid, 1'b1);
    chk(wr_cmd, c);
    chk(wr_data, d);
    chk(wr_word, w);
    if (k == 400) close_out;
    @(posedge ref_clk);
    wr_ready <= 1'b1;
    @(posedge ref_clk);
    wr_ready <= 1'b0;
  endtask : pop

  // Two writes wait in the buffer while the user stalls, then drain in order.
  task automatic t_buffer;
    logic n;
    wr_frame(ADDR, 8'h3C, 16'h00A5, 1'b0, 8'h00, 1'b0, n);
    chk(n, 1'b0);
    wr_frame(ADDR, 8'h81, 16'hC35A, 1'b1, 8'h00, 1'b0, n);
    chk(n, 1'b0);
    repeat (50) @(negedge ref_clk);
    pop(8'h3C, 16'h00A5, 1'b0);
    pop(8'h81, 16'hC35A, 1'b1);
    $display("buffer test done");
  endtask : t_buffer

  // Foreign address, bad checksum and a bare start-stop give no word.
  task automatic t_reject;
    logic n;
    wr_frame(7'h15, 8'h3C, 16'h0011, 1'b0, 8'h00, 1'b0, n);
    chk(n, 1'b1);
    wr_frame(ADDR, 8'h3C, 16'h0022, 1'b0, 8'h01, 1'b0, n);
    chk(n, 1'b0);
    u_bus_host.start;
    u_bus_host.stop;
    repeat (400) @(negedge ref_clk);
    chk(wr_valid, 1'b0);
    wr_frame(ADDR, 8'h44, 16'h0077, 1'b0, 8'h00, 1'b1, n);
    pop(8'h44, 16'h0077, 1'b0);
    $display("reject test done");
  endtask : t_reject

  // Read through a repeated start; the user answers the request.
  task automatic t_read(input logic w);
    logic [7:0] p, lo, hi, pc;
    logic       n, a;
    int         k;
    p = 8'h00;
    n = 1'b0;
    fork
      begin
        u_bus_host.start;
        put({ADDR, 1'b0}, p, n);
        put(8'h5E, p, n);
        u_bus_host.start;
        put({ADDR, 1'b1}, p, n);
        u_bus_host.xfer(8'hFF, 1'b0, lo, a);
        if (w) u_bus_host.xfer(8'hFF, 1'b0, hi, a);
        u_bus_host.xfer(8'hFF, 1'b1, pc, a);
        u_bus_host.stop;
      end
      begin
        for (k = 0; k < 4000 && rd_req !== 1'b1; k++) @(negedge ref_clk);
        chk(rd_cmd, 8'h5E);
        if (k == 4000) close_out;
        @(posedge ref_clk);
        rd_valid <= 1'b1;
        rd_data <= 16'h96E1;
        rd_word <= w;
        @(posedge ref_clk);
        rd_valid <= 1'b0;
        rd_data <= 16'h0000;
      end
    join
    chk(n, 1'b0);
    chk(lo, 8'hE1);
    p = crc(p, 8'hE1);
    if (w) chk(hi, 8'h96);
    if (w) p = crc(p, 8'h96);
    chk(pc, p);
    chk(stuck, 1'b0);
    if (stuck) close_out;
    $display("read test done");
  endtask : t_read

  // Reset, then each scenario in turn.
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    wr_ready = 1'b0;
    rd_valid = 1'b0;
    rd_word = 1'b0;
    rd_data = 16'h0000;
    errors = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    t_buffer;
    t_reject;
    t_read(1'b1);
    t_read(1'b0);
    close_out;
  end
endmodule : two_wire_slave_bench
